// ==== rtl/cxm_pkg.sv ====
package cxm_pkg;
   // Core clock rate and the period of the internal time base.
   localparam int CXM_CLK_MHZ = 40;
   localparam int CXM_TICK_NS = 1000;
   localparam int CXM_TICK_CYC = (CXM_TICK_NS * CXM_CLK_MHZ + 999) / 1000;
   // Dominant time-out in microseconds, a plain default to tune per system.
   localparam int CXM_DOM_TIMEOUT_US = 1000;
   localparam int CXM_DOM_TIMEOUT_TICKS =
      (CXM_DOM_TIMEOUT_US * 1000) / CXM_TICK_NS;
   localparam int CXM_TICK_W = 8;
   localparam int CXM_TMO_W = 16;
   localparam int CXM_RX_DEPTH = 16;
   localparam int CXM_RX_WIDTH = 1;
   // Reset values of the sampled pins: pulled up, hence high.
   localparam logic CXM_RST_TXD = 1'h1;
   localparam logic CXM_RST_QUIET = 1'h1;
   localparam logic CXM_RST_RXD = 1'h1;

   typedef enum logic [2:0] {
      CXM_DRV_FLOAT = 3'h1,
      CXM_DRV_WAIT = 3'h2,
      CXM_DRV_ON = 3'h4
   } cxm_drv_e;

   typedef struct packed {
      logic vcc_uv;
      logic vio_uv;
      logic over_temp;
   } cxm_supply_s;

   typedef struct packed {
      logic drive_dominant;
      logic release_float;
   } cxm_bus_s;
endpackage : cxm_pkg

// ==== rtl/cxm_fifo.sv ====
module cxm_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import cxm_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } cxm_fifo_s;

   cxm_fifo_s st;
   cxm_fifo_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_size
      $error("FIFO width or depth out of range.");
   end

   assign in_ready = (st.cnt != (AW + 1)'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data = mem[st.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr = st.wr + 1'h1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'h1;
      end
      next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[st.wr] <= in_data;
      end
   end

   count_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st.cnt <= (AW + 1)'(DEPTH))
      else $error("FIFO count exceeds its depth.");
endmodule // cxm_fifo

// ==== rtl/cxm_top.sv ====
module cxm_top #(
   parameter int TICK_CYC = cxm_pkg::CXM_TICK_CYC,
   parameter int DOM_TIMEOUT_TICKS = cxm_pkg::CXM_DOM_TIMEOUT_TICKS,
   parameter int RX_DEPTH = cxm_pkg::CXM_RX_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic transmit_data_in,
   input wire logic transmit_data_driven,
   input wire logic quiet_pin,
   input wire logic quiet_pin_driven,
   input wire cxm_pkg::cxm_supply_s supply_in,
   input wire logic bus_dominant_sense,
   input wire logic rx_ready,
   input wire logic overrun_clear,
   output cxm_pkg::cxm_bus_s bus_out,
   output logic receive_data_out,
   output logic silent_mode,
   output logic dominant_timeout_flag,
   output logic rx_overrun
);
   import cxm_pkg::*;

   typedef struct packed {
      logic txd;
      logic quiet;
      cxm_supply_s sup;
      cxm_drv_e drv;
      logic [CXM_TICK_W-1:0] tick_cnt;
      logic tick;
      logic [CXM_TMO_W-1:0] tmo_cnt;
      logic tmo_hit;
      cxm_bus_s bus;
      logic rxd;
      logic ovr;
   } cxm_state_s;

   localparam logic [CXM_TICK_W-1:0] TICK_LAST =
      CXM_TICK_W'(TICK_CYC - 1);
   localparam logic [CXM_TMO_W-1:0] TMO_LIMIT =
      CXM_TMO_W'(DOM_TIMEOUT_TICKS);

   cxm_state_s st;
   cxm_state_s next_st;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [CXM_RX_WIDTH-1:0] fifo_out_data;
   logic rx_pop;

   if (TICK_CYC < 2 || TICK_CYC > (1 << CXM_TICK_W)) begin : g_bad_tick
      $error("Time base divider out of range.");
   end
   if (DOM_TIMEOUT_TICKS < 1 ||
       DOM_TIMEOUT_TICKS >= (1 << CXM_TMO_W)) begin : g_bad_tmo
      $error("Dominant time-out out of counter range.");
   end

   // A bus supply fault overrides the thermal one: floating wins over off.
   function automatic logic supply_bad(input cxm_supply_s s);
      return s.vcc_uv || s.vio_uv;
   endfunction

   // Receive path: the sensed level is buffered and handed out on demand.
   // When the reader stalls the buffer fills and sampling stops; the lost
   // samples are reported rather than silently overwritten.
   cxm_fifo #(
      .WIDTH(CXM_RX_WIDTH),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(1'h1),
      .in_ready(fifo_in_ready),
      .in_data(CXM_RX_WIDTH'(~bus_dominant_sense)),
      .out_valid(fifo_out_valid),
      .out_ready(rx_ready),
      .out_data(fifo_out_data)
   );

   assign rx_pop = fifo_out_valid && rx_ready;

   always_comb begin
      next_st = st;
      next_st.txd = transmit_data_driven ? transmit_data_in : 1'h1;
      next_st.quiet = quiet_pin_driven ? quiet_pin : 1'h1;
      next_st.sup = supply_in;

      next_st.tick = (st.tick_cnt == TICK_LAST);
      if (st.tick_cnt == TICK_LAST) begin
         next_st.tick_cnt = '0;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 1'h1;
      end

      if (st.txd) begin
         next_st.tmo_cnt = '0;
         next_st.tmo_hit = 1'h0;
      end else if (st.tick && !st.tmo_hit) begin
         if (st.tmo_cnt == TMO_LIMIT) begin
            next_st.tmo_hit = 1'h1;
         end else begin
            next_st.tmo_cnt = st.tmo_cnt + 1'h1;
         end
      end

      unique case (st.drv)
         CXM_DRV_FLOAT: begin
            if (!supply_bad(st.sup)) begin
               next_st.drv = CXM_DRV_WAIT;
            end
         end
         CXM_DRV_WAIT: begin
            if (supply_bad(st.sup)) begin
               next_st.drv = CXM_DRV_FLOAT;
            end else if (!st.sup.over_temp && st.txd) begin
               next_st.drv = CXM_DRV_ON;
            end
         end
         CXM_DRV_ON: begin
            if (supply_bad(st.sup)) begin
               next_st.drv = CXM_DRV_FLOAT;
            end else if (st.sup.over_temp) begin
               next_st.drv = CXM_DRV_WAIT;
            end
         end
      endcase

      next_st.bus.drive_dominant = (st.drv == CXM_DRV_ON) && !st.quiet &&
                                   !st.txd && !st.tmo_hit;
      next_st.bus.release_float = (st.drv == CXM_DRV_FLOAT);

      if (rx_pop) begin
         next_st.rxd = fifo_out_data[0];
      end
      // A lost sample in the same cycle as the clear keeps the flag set.
      if (!fifo_in_ready) begin
         next_st.ovr = 1'h1;
      end else if (overrun_clear) begin
         next_st.ovr = 1'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st.txd <= CXM_RST_TXD;
         st.quiet <= CXM_RST_QUIET;
         st.sup <= '0;
         st.drv <= CXM_DRV_FLOAT;
         st.tick_cnt <= '0;
         st.tick <= 1'h0;
         st.tmo_cnt <= '0;
         st.tmo_hit <= 1'h0;
         st.bus <= '{drive_dominant: 1'h0, release_float: 1'h1};
         st.rxd <= CXM_RST_RXD;
         st.ovr <= 1'h0;
      end else begin
         st <= next_st;
      end
   end

   assign bus_out = st.bus;
   assign receive_data_out = st.rxd;
   assign silent_mode = st.quiet;
   assign dominant_timeout_flag = st.tmo_hit;
   assign rx_overrun = st.ovr;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   silent_tx_off_a: assert property (
      st.quiet |=> !bus_out.drive_dominant)
      else $error("Transmitter active in silent mode.");

   normal_drive_a: assert property (
      (st.drv == CXM_DRV_ON && !st.quiet && !st.txd && !st.tmo_hit)
      |=> bus_out.drive_dominant)
      else $error("Low transmit input did not drive dominant.");

   recessive_high_a: assert property (
      st.txd |=> !bus_out.drive_dominant)
      else $error("High transmit input drove dominant.");

   timeout_fire_a: assert property (
      $rose(st.tmo_hit) |-> $past(st.tmo_cnt) == TMO_LIMIT && !$past(st.txd)
      ##1 !bus_out.drive_dominant)
      else $error("Time-out fired at the wrong count or kept driving.");

   timeout_clear_a: assert property (
      st.txd |=> st.tmo_cnt == '0 && !st.tmo_hit)
      else $error("Time-out timer not cleared by high input.");

   pullup_default_a: assert property (
      (!transmit_data_driven && !quiet_pin_driven)
      |=> st.txd && st.quiet ##1 !bus_out.drive_dominant)
      else $error("Undriven inputs did not default high.");

   uv_float_a: assert property (
      supply_bad(st.sup) |=> st.drv == CXM_DRV_FLOAT
      ##1 bus_out.release_float && !bus_out.drive_dominant)
      else $error("Undervoltage did not float the bus.");

   driver_recover_a: assert property (
      (st.drv != CXM_DRV_ON ##1 st.drv == CXM_DRV_ON)
      |-> $past(st.txd) && !$past(st.sup.over_temp)
          && !supply_bad($past(st.sup)))
      else $error("Drivers returned without high input and good state.");

   ot_shutdown_a: assert property (
      st.sup.over_temp |=> st.drv != CXM_DRV_ON ##1 !bus_out.drive_dominant)
      else $error("Overtemperature left drivers enabled.");

   ot_hold_a: assert property (
      (st.drv == CXM_DRV_WAIT && !st.txd) |=> st.drv != CXM_DRV_ON)
      else $error("Drivers recovered while transmit input low.");

   rx_follow_a: assert property (
      rx_pop |=> receive_data_out == $past(fifo_out_data[0]))
      else $error("Receive output does not follow the buffered level.");

   tick_spacing_a: assert property (
      st.tick |=> !st.tick)
      else $error("Time base ticks back to back.");

   txd_sample_a: assert property (
      transmit_data_driven |=> st.txd == $past(transmit_data_in))
      else $error("Transmit input not registered.");

   quiet_sample_a: assert property (
      quiet_pin_driven |=> st.quiet == $past(quiet_pin))
      else $error("Mode input not registered.");

   sup_sample_a: assert property (
      rst_b |=> st.sup == $past(supply_in))
      else $error("Supply indications not registered.");

   txd_pullup_a: assert property (
      !transmit_data_driven |=> st.txd)
      else $error("Undriven transmit input did not read high.");

   quiet_pullup_a: assert property (
      !quiet_pin_driven |=> silent_mode)
      else $error("Undriven mode input did not select silent mode.");

   mode_dominant_a: assert property (
      bus_out.drive_dominant |-> !$past(st.quiet))
      else $error("Dominant driven while silent mode was selected.");

   drive_on_only_a: assert property (
      bus_out.drive_dominant |-> $past(st.drv) == CXM_DRV_ON)
      else $error("Dominant driven with drivers disabled.");

   float_uv_only_a: assert property (
      bus_out.release_float |-> $past(st.drv) == CXM_DRV_FLOAT)
      else $error("Bus floated outside the undervoltage state.");

   float_exclusive_a: assert property (
      bus_out.release_float |-> !bus_out.drive_dominant)
      else $error("Floating bus driven dominant.");

   float_exit_a: assert property (
      st.drv == CXM_DRV_FLOAT |=> st.drv != CXM_DRV_ON)
      else $error("Drivers enabled straight from the floating state.");

   ot_wait_a: assert property (
      (st.drv == CXM_DRV_WAIT && st.sup.over_temp) |=> st.drv != CXM_DRV_ON)
      else $error("Drivers recovered while still overheated.");

   drv_legal_a: assert property (
      $onehot(st.drv))
      else $error("Driver state code is not one-hot.");

   tmo_bound_a: assert property (
      st.tmo_cnt <= TMO_LIMIT)
      else $error("Time-out counter ran past its limit.");

   tmo_hold_a: assert property (
      (st.tmo_hit && !st.txd) |=> st.tmo_hit)
      else $error("Time-out released while transmit input low.");

   tmo_step_a: assert property (
      (st.tick && !st.txd && !st.tmo_hit && st.tmo_cnt != TMO_LIMIT)
      |=> st.tmo_cnt == $past(st.tmo_cnt) + 1'h1)
      else $error("Time-out counter missed a tick.");

   tmo_tick_only_a: assert property (
      (!st.tick && !st.txd) |=> $stable(st.tmo_cnt) && $stable(st.tmo_hit))
      else $error("Time-out advanced without a time base tick.");

   tick_bound_a: assert property (
      st.tick_cnt <= TICK_LAST)
      else $error("Time base divider ran past its end.");

   rx_hold_a: assert property (
      !rx_pop |=> $stable(receive_data_out))
      else $error("Receive output changed without a sample taken.");

   rx_silent_a: assert property (
      (st.quiet && rx_pop) |=> receive_data_out == $past(fifo_out_data[0]))
      else $error("Receiver stalled in silent mode.");

   overrun_set_a: assert property (
      !fifo_in_ready |=> rx_overrun)
      else $error("Lost sample did not set the overrun flag.");

   overrun_clear_a: assert property (
      (fifo_in_ready && overrun_clear) |=> !rx_overrun)
      else $error("Overrun flag not cleared.");

   overrun_hold_a: assert property (
      (rx_overrun && !overrun_clear) |=> rx_overrun)
      else $error("Overrun flag dropped without a clear.");
endmodule // cxm_top

// ==== test/cxm_ctrl_model.sv ====
module cxm_ctrl_model (
   input wire logic core_clk,
   output logic transmit_data_in,
   output logic transmit_data_driven,
   output logic quiet_pin,
   output logic quiet_pin_driven,
   output logic rx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins start undriven; an undriven data line carries no meaning, so it
   // shows low to prove that the pull-up is honoured.
   initial begin
      transmit_data_in = 1'h0;
      transmit_data_driven = 1'h0;
      quiet_pin = 1'h0;
      quiet_pin_driven = 1'h0;
      rx_ready = 1'h1;
   end
   task automatic drive(input logic tx, input logic quiet);
      @(posedge core_clk);
      transmit_data_in <= tx;
      transmit_data_driven <= 1'h1;
      quiet_pin <= quiet;
      quiet_pin_driven <= 1'h1;
   endtask
   task automatic go_silent();
      drive(1'h1, 1'h1);
   endtask
   task automatic set_ready(input logic r);
      @(posedge core_clk);
      rx_ready <= r;
   endtask
endmodule // cxm_ctrl_model

// ==== test/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cxm_pkg::*;
   logic core_clk;
   logic rst_b;
   logic tx, tx_drv, quiet, quiet_drv, rx_ready;
   cxm_supply_s supply_in;
   logic other_dom, overrun_clear;
   cxm_bus_s bus;
   logic rxd, silent, tmo, ovr;
   wire logic sense = bus.drive_dominant | other_dom;
   int err_count = 0;
   int checks = 0;

   cxm_ctrl_model ctl (.core_clk(core_clk), .transmit_data_in(tx),
      .transmit_data_driven(tx_drv), .quiet_pin(quiet),
      .quiet_pin_driven(quiet_drv), .rx_ready(rx_ready));
   cxm_top #(.TICK_CYC(2), .DOM_TIMEOUT_TICKS(3)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .transmit_data_in(tx),
      .transmit_data_driven(tx_drv), .quiet_pin(quiet),
      .quiet_pin_driven(quiet_drv), .supply_in(supply_in),
      .bus_dominant_sense(sense), .rx_ready(rx_ready),
      .overrun_clear(overrun_clear), .bus_out(bus),
      .receive_data_out(rxd), .silent_mode(silent),
      .dominant_timeout_flag(tmo), .rx_overrun(ovr));

   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic chk(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %b seen %b", name, exp, got);
         err_count++;
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic t_reset();
      step(6);
      chk("release_float", 1'h1, bus.release_float);
      chk("receive_data_out", 1'h1, rxd);
      chk("silent_mode", 1'h1, silent);
      chk("timeout_flag", 1'h0, tmo);
      chk("rx_overrun", 1'h0, ovr);
      $display("test reset done");
   endtask
   task automatic t_float();
      step(4);
      chk("silent_mode", 1'h1, silent);
      chk("drive_dominant", 1'h0, bus.drive_dominant);
      chk("release_float", 1'h0, bus.release_float);
      $display("test float done");
   endtask
   task automatic t_normal();
      ctl.drive(1'h0, 1'h0);
      step(5);
      chk("drive_dominant", 1'h1, bus.drive_dominant);
      chk("receive_data_out", 1'h0, rxd);
      ctl.drive(1'h1, 1'h0);
      step(5);
      chk("drive_dominant", 1'h0, bus.drive_dominant);
      chk("receive_data_out", 1'h1, rxd);
      chk("silent_mode", 1'h0, silent);
      $display("test normal done");
   endtask
   task automatic t_silent();
      ctl.go_silent();
      ctl.drive(1'h0, 1'h1);
      step(5);
      chk("drive_dominant", 1'h0, bus.drive_dominant);
      chk("silent_mode", 1'h1, silent);
      @(posedge core_clk) other_dom <= 1'h1;
      step(4);
      chk("receive_data_out", 1'h0, rxd);
      @(posedge core_clk) other_dom <= 1'h0;
      ctl.go_silent();
      step(4);
      chk("receive_data_out", 1'h1, rxd);
      $display("test silent done");
   endtask
   task automatic t_timeout();
      ctl.drive(1'h1, 1'h0);
      step(3);
      ctl.drive(1'h0, 1'h0);
      step(5);
      ctl.drive(1'h1, 1'h0);
      ctl.drive(1'h0, 1'h0);
      step(3);
      chk("timeout_flag", 1'h0, tmo);
      chk("drive_dominant", 1'h1, bus.drive_dominant);
      step(12);
      chk("timeout_flag", 1'h1, tmo);
      chk("drive_dominant", 1'h0, bus.drive_dominant);
      ctl.drive(1'h1, 1'h0);
      step(3);
      chk("timeout_flag", 1'h0, tmo);
      $display("test timeout done");
   endtask
   task automatic t_faults();
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk) supply_in <= 3'h1 << i;
         step(3);
         ctl.drive(1'h0, 1'h0);
         step(3);
         chk("drive_dominant", 1'h0, bus.drive_dominant);
         if (i > 0) chk("release_float", 1'h1, bus.release_float);
         @(posedge core_clk) supply_in <= 3'h0;
         step(3);
         chk("drive_dominant", 1'h0, bus.drive_dominant);
         ctl.drive(1'h1, 1'h0);
         ctl.drive(1'h0, 1'h0);
         step(3);
         chk("drive_dominant", 1'h1, bus.drive_dominant);
         ctl.drive(1'h1, 1'h0);
         step(3);
      end
      $display("test faults done");
   endtask
   task automatic t_overrun();
      ctl.set_ready(1'h0);
      step(24);
      chk("rx_overrun", 1'h1, ovr);
      ctl.set_ready(1'h1);
      step(4);
      @(posedge core_clk) overrun_clear <= 1'h1;
      @(posedge core_clk) overrun_clear <= 1'h0;
      step(4);
      chk("rx_overrun", 1'h0, ovr);
      chk("receive_data_out", 1'h1, rxd);
      $display("test overrun done");
   endtask

   initial begin
      rst_b = 1'h0;
      supply_in = 3'h0;
      other_dom = 1'h0;
      overrun_clear = 1'h0;
      t_reset();
      @(posedge core_clk) rst_b <= 1'h1;
      t_float();
      t_normal();
      t_silent();
      t_timeout();
      t_faults();
      t_overrun();
      report_and_stop();
   end

   // The whole sequence takes about 170 cycles.
   initial begin
      repeat (3000) @(posedge core_clk);
      err_count++;
      $display("ERROR watchdog expected finish seen hang");
      report_and_stop();
   end
endmodule // testbench
